// >>> verilog/dbg_unit_pkg.sv
// Constants, field layouts and carrier types of the tile debug unit
package dbg_unit_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_SAVED_STATUS  = 8'h10;
  localparam logic [7:0] IDX_SAVED_PC      = 8'h11;
  localparam logic [7:0] IDX_SAVED_SP      = 8'h12;
  localparam logic [7:0] IDX_READ_THREAD   = 8'h13;
  localparam logic [7:0] IDX_READ_INDEX    = 8'h14;
  localparam logic [7:0] IDX_ENTRY_CAUSE   = 8'h15;
  localparam logic [7:0] IDX_ENTRY_DATA    = 8'h16;
  localparam logic [7:0] IDX_HALT_MASK     = 8'h18;
  localparam logic [7:0] IDX_SCRATCH_BASE  = 8'h20;
  localparam logic [7:0] IDX_IBRK_ADDR     = 8'h30;
  localparam logic [7:0] IDX_IBRK_CTRL     = 8'h40;
  localparam logic [7:0] IDX_DWATCH_ADDR   = 8'h50;

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  localparam int STATUS_W        = 11;  // Bits 10:0 of the status word
  localparam int ST_ISSUE_MODE   = 8;   // Read-only current issue mode
  localparam int CAUSE_THREAD_LO = 8;   // Source thread field 15:8
  localparam int CAUSE_INDEX_LO  = 16;  // Breakpoint index field 17:16
  localparam int CTRL_MASK_LO    = 16;  // Per-thread enables 23:16
  localparam int CTRL_NOTEQ_BIT  = 1;
  localparam int CTRL_EN_BIT     = 0;
  localparam int THREAD_W        = 8;
  localparam int REGIDX_W        = 5;
  localparam int NUM_BRK         = 4;
  localparam int NUM_SCRATCH     = 8;

  // ****************************************************************
  // Cause codes and reset values
  // ****************************************************************
  localparam logic [2:0] CAUSE_NONE     = 3'h0;
  localparam logic [2:0] CAUSE_HOST     = 3'h1;
  localparam logic [2:0] CAUSE_CALL     = 3'h2;
  localparam logic [2:0] CAUSE_IBREAK   = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH   = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH   = 3'h5;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic                valid;   // An instruction issues this cycle
    logic [THREAD_W-1:0] thread;
    logic [31:0]         pc;
    logic [31:0]         sp;
    logic [STATUS_W-1:0] status;
  } issue_t;

  typedef struct packed {
    logic [THREAD_W-1:0] threadMask;
    logic                notEqual;
    logic                enable;
  } brk_ctrl_t;

  typedef struct packed {
    logic [NUM_BRK-1:0]  hit;
    logic [THREAD_W-1:0] thread;
    logic [31:0]         data;     // Effective address or resource id
  } watch_t;

endpackage : dbg_unit_pkg

// >>> verilog/tile_debug_breakpoint_unit.sv
// Debug snapshot, cause recording and instruction breakpoint unit
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module tile_debug_breakpoint_unit
  import dbg_unit_pkg::*;
#(
  parameter int ADR_W = 10
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Wishbone classic slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [ADR_W-1:0]     adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  // Issue stage of the core
  input  wire issue_t               issue,
  // Debug sources
  input  wire logic                 hostRequest,
  input  wire logic                 debugCallValid,
  input  wire logic [THREAD_W-1:0]  debugCallThread,
  input  wire watch_t               dataWatch,
  input  wire watch_t               resWatch,
  input  wire logic                 debugReturn,
  // Tile configuration access to the scratch words
  input  wire logic                 cfgScratchWe,
  input  wire logic [2:0]           cfgScratchIdx,
  input  wire logic [31:0]          cfgScratchWdata,
  output logic      [31:0]          cfgScratchRdata,
  // Core control outputs
  output logic                      debugEnter,
  output logic                      inDebug,
  output logic      [THREAD_W-1:0]  haltThreads,
  output logic      [THREAD_W-1:0]  readThread,
  output logic      [REGIDX_W-1:0]  readIndex,
  output logic      [NUM_BRK*32-1:0] dataWatchFirst
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // Merge write data into an old word under the byte enables
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldW,
                                             input logic [31:0] newW,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = oldW;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = newW[b*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // True when idx lies in a block of 2**lg registers at base
  function automatic logic inBlock(input logic [7:0] idx,
                                   input logic [7:0] base,
                                   input int         lg);
    logic [7:0] mask;
    mask = 8'hff << lg;
    return (idx & mask) == base;
  endfunction : inBlock

  // Lowest set bit of a hit vector
  function automatic logic [1:0] lowestHit(input logic [NUM_BRK-1:0] h);
    logic [1:0] res;
    res = 2'h0;
    for (int i = NUM_BRK - 1; i >= 0; i--) begin
      if (h[i]) begin
        res = 2'(i);
      end
    end
    return res;
  endfunction : lowestHit

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [STATUS_W-1:0] savedStatus_r;
  logic [31:0]         savedPc_r;
  logic [31:0]         savedSp_r;
  logic [THREAD_W-1:0] readThread_r;
  logic [REGIDX_W-1:0] readIndex_r;
  logic [2:0]          cause_r;
  logic [THREAD_W-1:0] causeThread_r;
  logic [1:0]          causeIndex_r;
  logic [31:0]         entryData_r;
  logic [THREAD_W-1:0] haltMask_r;
  logic [THREAD_W-1:0] haltOut_r;
  logic [31:0]         scratch_r [NUM_SCRATCH];
  logic [31:0]         ibrkAddr_r [NUM_BRK];
  brk_ctrl_t           ibrkCtrl_r [NUM_BRK];
  logic [31:0]         dwAddr_r [NUM_BRK];
  logic                inDebug_r;
  logic                inDebug_nxt;
  logic                ack_r;
  logic [31:0]         datOut_r;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [7:0]  wordIdx;
  logic        busReq;
  logic        busWrite;
  logic [31:0] readWord;
  logic [31:0] wrMerged;

  assign wordIdx = adr_i[9:2];
  assign busReq  = cyc_i & stb_i;
  // Write lands on the edge where the master sees ack; gated by mode
  assign busWrite = busReq & we_i & ack_r & inDebug_r;
  // Addressed word as it reads, with the write bytes laid over it
  assign wrMerged = mergeBytes(readWord, dat_i, sel_i);

  // ****************************************************************
  // Instruction breakpoint compare
  // ****************************************************************
  logic [NUM_BRK-1:0] ibrkHit;

  genvar g;
  generate
    for (g = 0; g < NUM_BRK; g++) begin : gBrk
      logic pcEq;
      assign pcEq = issue.pc == ibrkAddr_r[g];
      // Each breakpoint fires on its own settings alone
      assign ibrkHit[g] = issue.valid
        & ibrkCtrl_r[g].enable
        & ibrkCtrl_r[g].threadMask[issue.thread[2:0]]
        & (ibrkCtrl_r[g].notEqual ? ~pcEq : pcEq);
    end
  endgenerate

  // ****************************************************************
  // Entry arbitration
  // ****************************************************************
  logic       anyIbrk;
  logic       anyData;
  logic       anyRes;
  logic [2:0] causeSel;

  assign anyIbrk = |ibrkHit;
  assign anyData = |dataWatch.hit;
  assign anyRes  = |resWatch.hit;

  // Fixed priority: host, call, ibreak, data watch, resource watch
  always_comb begin
    if (hostRequest) begin
      causeSel = CAUSE_HOST;
    end else if (debugCallValid) begin
      causeSel = CAUSE_CALL;
    end else if (anyIbrk) begin
      causeSel = CAUSE_IBREAK;
    end else if (anyData) begin
      causeSel = CAUSE_DWATCH;
    end else if (anyRes) begin
      causeSel = CAUSE_RWATCH;
    end else begin
      causeSel = CAUSE_NONE;
    end
  end

  // Combinational so the core can squash the instruction in flight
  assign debugEnter = ~inDebug_r & (causeSel != CAUSE_NONE);

  // ****************************************************************
  // Debug mode state
  // ****************************************************************
  always_comb begin
    inDebug_nxt = inDebug_r;
    if (debugEnter) begin
      inDebug_nxt = 1'b1;
    end else if (debugReturn) begin
      inDebug_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      inDebug_r <= 1'b0;
    end else begin
      inDebug_r <= inDebug_nxt;
    end
  end

  assign inDebug = inDebug_r;

  // ****************************************************************
  // Thread snapshot
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      savedStatus_r <= '0;
      savedPc_r     <= WORD_RESET;
      savedSp_r     <= WORD_RESET;
    end else if (debugEnter) begin
      savedStatus_r <= issue.status;
      savedPc_r     <= issue.pc;
      savedSp_r     <= issue.sp;
    end else if (busWrite) begin
      unique case (wordIdx)
        IDX_SAVED_STATUS: begin
          // Current issue mode stays read-only
          savedStatus_r <= {wrMerged[STATUS_W-1:ST_ISSUE_MODE+1],
                            savedStatus_r[ST_ISSUE_MODE],
                            wrMerged[ST_ISSUE_MODE-1:0]};
        end
        IDX_SAVED_PC: savedPc_r <= mergeBytes(savedPc_r, dat_i, sel_i);
        IDX_SAVED_SP: savedSp_r <= mergeBytes(savedSp_r, dat_i, sel_i);
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Cause, source thread, index and data
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_r       <= CAUSE_NONE;
      causeThread_r <= '0;
      causeIndex_r  <= 2'h0;
    end else if (debugEnter) begin
      cause_r <= causeSel;
      unique case (causeSel)
        CAUSE_HOST: begin
          causeThread_r <= '0;
          causeIndex_r  <= 2'h0;
        end
        CAUSE_CALL: begin
          causeThread_r <= debugCallThread;
          causeIndex_r  <= 2'h0;
        end
        CAUSE_IBREAK: begin
          causeThread_r <= issue.thread;
          causeIndex_r  <= lowestHit(ibrkHit);
        end
        CAUSE_DWATCH: begin
          causeThread_r <= dataWatch.thread;
          causeIndex_r  <= lowestHit(dataWatch.hit);
        end
        default: begin
          causeThread_r <= resWatch.thread;
          causeIndex_r  <= lowestHit(resWatch.hit);
        end
      endcase
    end else if (busWrite && wordIdx == IDX_ENTRY_CAUSE) begin
      cause_r       <= wrMerged[2:0];
      causeThread_r <= wrMerged[CAUSE_THREAD_LO +: THREAD_W];
      causeIndex_r  <= wrMerged[CAUSE_INDEX_LO +: 2];
    end
  end

  // Data word only changes on watchpoint entries or software writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      entryData_r <= WORD_RESET;
    end else if (debugEnter && causeSel == CAUSE_DWATCH) begin
      entryData_r <= dataWatch.data;
    end else if (debugEnter && causeSel == CAUSE_RWATCH) begin
      entryData_r <= resWatch.data;
    end else if (busWrite && wordIdx == IDX_ENTRY_DATA) begin
      entryData_r <= mergeBytes(entryData_r, dat_i, sel_i);
    end
  end

  // ****************************************************************
  // Register-read operands and halt mask
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      readThread_r <= '0;
      readIndex_r  <= '0;
      haltMask_r   <= '0;
    end else if (busWrite) begin
      unique case (wordIdx)
        IDX_READ_THREAD: readThread_r <= wrMerged[THREAD_W-1:0];
        IDX_READ_INDEX:  readIndex_r  <= wrMerged[REGIDX_W-1:0];
        IDX_HALT_MASK:   haltMask_r   <= wrMerged[THREAD_W-1:0];
        default: ;
      endcase
    end
  end

  // Halted threads only matter once debug mode is left
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      haltOut_r <= '0;
    end else begin
      haltOut_r <= inDebug_nxt ? '0 : haltMask_r;
    end
  end

  assign haltThreads = haltOut_r;
  assign readThread  = readThread_r;
  assign readIndex   = readIndex_r;

  // ****************************************************************
  // Scratch words, shared with the configuration path
  // ****************************************************************
  // Bus write wins a same-cycle clash on one word; the other is lost
  generate
    for (g = 0; g < NUM_SCRATCH; g++) begin : gScr
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          scratch_r[g] <= WORD_RESET;
        end else if (busWrite
                     && wordIdx == IDX_SCRATCH_BASE + 8'(g)) begin
          scratch_r[g] <= mergeBytes(scratch_r[g], dat_i, sel_i);
        end else if (cfgScratchWe && cfgScratchIdx == 3'(g)) begin
          scratch_r[g] <= cfgScratchWdata;
        end
      end
    end
  endgenerate

  assign cfgScratchRdata = scratch_r[cfgScratchIdx];

  // ****************************************************************
  // Breakpoint and watchpoint registers
  // ****************************************************************
  generate
    for (g = 0; g < NUM_BRK; g++) begin : gBrkReg
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          ibrkAddr_r[g] <= WORD_RESET;
          ibrkCtrl_r[g] <= '0;
          dwAddr_r[g]   <= WORD_RESET;
        end else if (busWrite) begin
          if (wordIdx == IDX_IBRK_ADDR + 8'(g)) begin
            ibrkAddr_r[g] <= mergeBytes(ibrkAddr_r[g], dat_i, sel_i);
          end
          if (wordIdx == IDX_IBRK_CTRL + 8'(g)) begin
            ibrkCtrl_r[g].threadMask <=
              wrMerged[CTRL_MASK_LO +: THREAD_W];
            ibrkCtrl_r[g].notEqual <= wrMerged[CTRL_NOTEQ_BIT];
            ibrkCtrl_r[g].enable   <= wrMerged[CTRL_EN_BIT];
          end
          if (wordIdx == IDX_DWATCH_ADDR + 8'(g)) begin
            dwAddr_r[g] <= mergeBytes(dwAddr_r[g], dat_i, sel_i);
          end
        end
      end

      assign dataWatchFirst[g*32 +: 32] = dwAddr_r[g];
    end
  endgenerate

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  // Unmapped words and reserved bits read as zero
  always_comb begin
    readWord = 32'h0000_0000;
    if (inBlock(wordIdx, IDX_SCRATCH_BASE, 3)) begin
      readWord = scratch_r[wordIdx[2:0]];
    end else if (inBlock(wordIdx, IDX_IBRK_ADDR, 2)) begin
      readWord = ibrkAddr_r[wordIdx[1:0]];
    end else if (inBlock(wordIdx, IDX_IBRK_CTRL, 2)) begin
      readWord = {8'h00, ibrkCtrl_r[wordIdx[1:0]].threadMask, 14'h0000,
                  ibrkCtrl_r[wordIdx[1:0]].notEqual,
                  ibrkCtrl_r[wordIdx[1:0]].enable};
    end else if (inBlock(wordIdx, IDX_DWATCH_ADDR, 2)) begin
      readWord = dwAddr_r[wordIdx[1:0]];
    end else begin
      unique case (wordIdx)
        IDX_SAVED_STATUS: readWord = {21'h000000, savedStatus_r};
        IDX_SAVED_PC:     readWord = savedPc_r;
        IDX_SAVED_SP:     readWord = savedSp_r;
        IDX_READ_THREAD:  readWord = {24'h000000, readThread_r};
        IDX_READ_INDEX:   readWord = {27'h0000000, readIndex_r};
        IDX_ENTRY_CAUSE: begin
          readWord = {14'h0000, causeIndex_r, causeThread_r, 5'h00,
                      cause_r};
        end
        IDX_ENTRY_DATA:   readWord = entryData_r;
        IDX_HALT_MASK:    readWord = {24'h000000, haltMask_r};
        default:          readWord = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Wishbone acknowledge and read data
  // ****************************************************************
  // One wait state: ack rises the cycle after the request, then drops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_r    <= 1'b0;
      datOut_r <= 32'h0000_0000;
    end else begin
      ack_r <= busReq & ~ack_r;
      if (busReq && !ack_r) begin
        datOut_r <= readWord;
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = datOut_r;

endmodule : tile_debug_breakpoint_unit

// >>> test/dbg_unit_asserts.sv
// Concurrent checks on the debug unit's bus and debug-entry ports
`timescale 1ns/1ps
// ****************************************************************
// Port checker
// ****************************************************************
module dbg_unit_asserts
  import dbg_unit_pkg::*;
(
  // Clock, reset and bus handshake
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                ack_o,
  // Debug sources and core control
  input wire issue_t              issue,
  input wire logic                hostRequest,
  input wire logic                debugCallValid,
  input wire watch_t              dataWatch,
  input wire watch_t              resWatch,
  input wire logic                debugReturn,
  input wire logic                debugEnter,
  input wire logic                inDebug,
  input wire logic [THREAD_W-1:0] haltThreads
);
  // Single domain, so clock and reset are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Bus handshake: answer one cycle after a request, then drop
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked next cycle");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  // Host, call and watch causes seen outside debug mode raise entry at once
  host_enter_a: assert property (
    hostRequest && !inDebug |-> debugEnter)
    else $error("host request did not enter debug");
  call_enter_a: assert property (
    debugCallValid && !inDebug |-> debugEnter)
    else $error("debug call did not enter debug");
  watch_enter_a: assert property (
    (dataWatch.hit != 0 || resWatch.hit != 0) && !inDebug |-> debugEnter)
    else $error("watch hit did not enter debug");
  // No instruction and no source means no entry
  quiet_no_enter_a: assert property (!issue.valid && !hostRequest
    && !debugCallValid && dataWatch.hit == 0 && resWatch.hit == 0
    |-> !debugEnter) else $error("entry without a cause");
  // Entry stops every thread gate and holds until return
  enter_mode_a: assert property (
    debugEnter |=> inDebug && haltThreads == 0)
    else $error("entry did not set debug mode");
  debug_refuse_a: assert property (inDebug |-> !debugEnter)
    else $error("entry raised inside debug mode");
  debug_hold_a: assert property (inDebug && !debugReturn |=> inDebug)
    else $error("debug mode left without return");
  debug_leave_a: assert property (
    inDebug && debugReturn |=> !inDebug)
    else $error("return did not leave debug mode");
  // Main scenarios reached
  cover property (debugEnter && issue.valid);
  cover property (debugEnter && dataWatch.hit != 0);
  cover property (inDebug && debugReturn);
endmodule : dbg_unit_asserts

bind tile_debug_breakpoint_unit dbg_unit_asserts u_dbg_unit_asserts (
  .ref_clk, .rst, .cyc_i, .stb_i, .ack_o, .issue, .hostRequest,
  .debugCallValid, .dataWatch, .resWatch, .debugReturn, .debugEnter,
  .inDebug, .haltThreads);

// >>> test/dbg_source_model.sv
// Model of the core and host that raise debug causes
`timescale 1ns/1ps
// ****************************************************************
// Debug source model
// ****************************************************************
module dbg_source_model
  import dbg_unit_pkg::*;
(
  // Clock
  input  wire logic          ref_clk,
  // Causes toward the unit
  output issue_t             issue,
  output logic               hostRequest,
  output logic               debugCallValid,
  output logic [THREAD_W-1:0] debugCallThread,
  output watch_t             dataWatch,
  output watch_t             resWatch,
  output logic               debugReturn
);
  // Idle at time zero
  initial begin
    issue = '0;
    hostRequest = 1'b0;
    debugCallValid = 1'b0;
    debugCallThread = '0;
    dataWatch = '0;
    resWatch = '0;
    debugReturn = 1'b0;
  end
  // One-cycle cause: 0 issue, 1 host, 2 call, 4 data, 5 resource, 6 return
  // Idle payloads show the inverse so stale values cannot pass for fresh
  task automatic pulse(input issue_t i, input int kind,
                       input logic [7:0] t, input watch_t w);
    @(posedge ref_clk);
    issue <= i;
    hostRequest <= kind == 1;
    debugCallValid <= kind == 2;
    debugCallThread <= t;
    dataWatch <= (kind == 4) ? w : {4'h0, ~w[39:0]};
    resWatch <= (kind == 5) ? w : {4'h0, ~w[39:0]};
    debugReturn <= kind == 6;
    @(posedge ref_clk);
    issue <= {1'b0, ~i[$bits(issue_t)-2:0]};
    hostRequest <= 1'b0;
    debugCallValid <= 1'b0;
    debugCallThread <= ~t;
    dataWatch <= {4'h0, ~w[39:0]};
    resWatch <= {4'h0, ~w[39:0]};
    debugReturn <= 1'b0;
  endtask : pulse
endmodule : dbg_source_model

// >>> test/tb.sv
// Self-checking bench of the tile debug unit
`timescale 1ns/1ps
// ****************************************************************
// Bench
// ****************************************************************
module tb
  import dbg_unit_pkg::*;
;
  logic ref_clk = 0, rst = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [9:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, cfgScratchWdata = '0, q, dat_o, cfgScratchRdata;
  logic cfgScratchWe = 0, ack_o, debugEnter, inDebug;
  logic [2:0] cfgScratchIdx = '0;
  logic [7:0] haltThreads, readThread, debugCallThread;
  logic [4:0] readIndex;
  logic [127:0] dataWatchFirst;
  logic hostRequest, debugCallValid, debugReturn;
  issue_t issue;
  watch_t dataWatch, resWatch;
  int errTotal = 0, nCompared = 0;
  // Breakpoint setup and entry table
  logic [31:0] ba[4] = '{32'h1000, 32'h1004, 32'h1004, 32'h1008};
  logic [31:0] bc[4] = '{32'h1_0001, 32'h1_0001, 32'h3_0001, 32'h80_0003};
  int kd[7] = '{0, 0, 0, 0, 2, 4, 5};
  logic [7:0] th[7] = '{1, 0, 7, 7, 6, 5, 2};
  logic [31:0] pv[7] = '{32'h1004, 32'h1004, 32'h1008, 32'h2000, 0, 0, 0};
  logic [3:0] hv[7] = '{0, 0, 0, 0, 0, 4'b0110, 4'b1000};
  logic [31:0] ec[7] = '{32'h20103, 32'h10003, 0, 32'h30703, 32'h602,
                         32'h10504, 32'h30205};
  `define CHK(nm, e, s) begin nCompared++; if ((s) !== (e)) begin \
    errTotal++; $display("BAD %s exp %h got %h", nm, e, s); end end

  always #2.5 ref_clk = ~ref_clk;
  tile_debug_breakpoint_unit u_tile_debug_breakpoint_unit (.*);
  dbg_source_model u_dbg_source_model (.*);

  // Classic Wishbone cycle; waits for ack with no assumed latency
  task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge ref_clk);
    {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'hf};
    adr_i <= {i, 2'b00};
    dat_i <= d;
    @(posedge ref_clk iff ack_o === 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  task automatic rdx(input logic [7:0] i, input logic [31:0] e);
    wb(1'b0, i, 32'h0);
    `CHK($sformatf("reg %h", i), e, q)
  endtask : rdx
  task automatic results();
    $display("Compared %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    results();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rdx(IDX_ENTRY_CAUSE, 0);
    rdx(IDX_IBRK_CTRL, 0);
    wb(1'b1, IDX_IBRK_ADDR, 32'h1);
    rdx(IDX_IBRK_ADDR, 0);
    u_dbg_source_model.pulse('{1'b0, 8'h3, 32'hc0de_0100, 32'h5a5a_0010,
                              11'h1d5}, 1, 8'h0, '0);
    rdx(IDX_ENTRY_CAUSE, 32'h1);
    rdx(IDX_SAVED_STATUS, 32'h1d5);
    rdx(IDX_SAVED_PC, 32'hc0de_0100);
    rdx(IDX_SAVED_SP, 32'h5a5a_0010);
    wb(1'b1, IDX_SAVED_STATUS, 32'hffff_fedf);
    rdx(IDX_SAVED_STATUS, 32'h7df);
    wb(1'b1, IDX_READ_THREAD, 32'h1ff);
    rdx(IDX_READ_THREAD, 32'hff);
    wb(1'b1, IDX_READ_INDEX, 32'hff);
    rdx(IDX_READ_INDEX, 32'h1f);
    `CHK("operands", 13'h1fff, {readThread, readIndex})
    for (int g = 0; g < 4; g++) begin
      wb(1'b1, IDX_IBRK_ADDR + g, ba[g]);
      wb(1'b1, IDX_IBRK_CTRL + g, bc[g]);
      wb(1'b1, IDX_DWATCH_ADDR + g, 32'hd000_0000 + g);
      rdx(IDX_IBRK_CTRL + g, bc[g]);
      `CHK("watch addr", 32'hd000_0000 + g, dataWatchFirst[g*32+:32])
    end
    for (int s = 0; s < 8; s++) begin
      wb(1'b1, IDX_SCRATCH_BASE + s, 32'h5c00 + s);
      cfgScratchIdx <= s[2:0];
      @(negedge ref_clk);
      `CHK("scratch", 32'h5c00 + s, cfgScratchRdata)
    end
    @(posedge ref_clk);
    {cfgScratchWe, cfgScratchWdata} <= {1'b1, 32'hfeed};
    @(posedge ref_clk);
    cfgScratchWe <= 1'b0;
    rdx(IDX_SCRATCH_BASE + 7, 32'hfeed);
    wb(1'b1, IDX_HALT_MASK, 32'h140);
    rdx(IDX_HALT_MASK, 32'h40);
    rdx(8'h70, 0);
    u_dbg_source_model.pulse('0, 6, 8'h0, '0);
    @(negedge ref_clk);
    `CHK("halt", 9'h040, {inDebug, haltThreads})
    for (int k = 0; k < 7; k++) begin
      u_dbg_source_model.pulse('{kd[k] == 0, th[k], pv[k], 32'h0, 11'h0},
                               kd[k], th[k], '{hv[k], th[k], 32'hab00 + k});
      @(negedge ref_clk);
      `CHK("entered", ec[k] != 0, inDebug)
      if (ec[k] != 0) rdx(IDX_ENTRY_CAUSE, ec[k]);
      if (kd[k] >= 4) rdx(IDX_ENTRY_DATA, 32'hab00 + k);
      u_dbg_source_model.pulse('0, 6, 8'h0, '0);
    end
    results();
  end
endmodule : tb
